// >>> hw/aos_defines.vh
`ifndef AOS_DEFINES_VH
`define AOS_DEFINES_VH

// register byte offsets on the bus
`define AOS_OFF_CTRL      8'h00
`define AOS_OFF_SLO       8'h04
`define AOS_OFF_SHI       8'h08
`define AOS_OFF_LEXT      8'h0c
`define AOS_OFF_HEXT      8'h10
`define AOS_OFF_GAP       8'h14
`define AOS_OFF_STAT      8'h18
`define AOS_OFF_MASK      8'h1c
`define AOS_OFF_OUT       8'h20

// control register fields and reset value
`define AOS_CTRL_MODE     2:0
`define AOS_CTRL_SRC      3
`define AOS_CTRL_FLT      6:4
`define AOS_CTRL_RST      7'h00

// output modes
`define AOS_MODE_OFF      3'h0
`define AOS_MODE_0_20     3'h1
`define AOS_MODE_4_20     3'h2
`define AOS_MODE_0_5      3'h3
`define AOS_MODE_1_5      3'h4
`define AOS_MODE_0_10     3'h5
`define AOS_MODE_2_10     3'h6
`define AOS_MODE_BUS      3'h7

// output kinds (hardware version)
`define AOS_KIND_ACUR     2'h0
`define AOS_KIND_PCUR     2'h1
`define AOS_KIND_AVOLT    2'h2

// levels, microamperes or millivolts
`define AOS_LV_0          16'h0000
`define AOS_LV_20MA       16'h4e20
`define AOS_LV_4MA        16'h0fa0
`define AOS_LV_5V         16'h1388
`define AOS_LV_10V        16'h2710
`define AOS_LV_1V         16'h03e8
`define AOS_LV_2V         16'h07d0
`define AOS_LV_22_1MA     16'h5654
`define AOS_LV_3_4MA      16'h0d48
`define AOS_LV_11V        16'h2af8
`define AOS_LV_5_5V       16'h157c
`define AOS_LV_1_2V       16'h04b0
`define AOS_LV_0_6V       16'h0258

// fault choice codes
`define AOS_FLT_KEEP      3'h0

// extension percentages in thousandths of a percent
`define AOS_PCT_FULL      33'h0000186a0
`define AOS_LEXT_MAX_A    17'h1869f
`define AOS_LEXT_MAX_P    17'h0752f
`define AOS_HEXT_MAX_C    17'h04e1f
`define AOS_HEXT_MAX_V    17'h0270f

// frame gap limit in seconds
`define AOS_GAP_MAX       7'h63

// timing: one second and the clock period, in ns
`define AOS_SEC_NS        32'h3b9aca00
`define AOS_CLK_NS        32'h00000005

// status event bits
`define AOS_EV_CLAMP      0
`define AOS_EV_FAULT      1
`define AOS_EV_GAP        2
`define AOS_EV_REJECT     3

`endif

// >>> hw/aos_divider.v
`timescale 1ns/100ps
// unsigned restoring divider, one quotient bit per clock
module aos_divider #(
	parameter W = 50
) (
	input  wire         clk,
	input  wire         rstn,
	input  wire         start,
	input  wire [W-1:0] dividend,
	input  wire [W-1:0] divisor,
	output reg          done,
	output reg  [W-1:0] quotient
);
	reg  [W-1:0] rem;           // partial remainder
	reg  [W-1:0] dsr;           // divisor held during the run
	reg  [7:0]   cnt;           // bits still to produce
	wire [W:0]   shifted = {rem, quotient[W-1]};
	wire         fits    = (shifted >= {1'b0, dsr});
	wire [W:0]   trial   = shifted - {1'b0, dsr};

	// shift-subtract loop; done pulses one cycle with the result
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rem      <= {W{1'b0}};
			dsr      <= {W{1'b0}};
			quotient <= {W{1'b0}};
			cnt      <= 8'h00;
			done     <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				rem      <= {W{1'b0}};
				dsr      <= divisor;
				quotient <= dividend;
				cnt      <= W[7:0];
			end else if (cnt != 8'h00) begin
				// take the bit when the divisor fits
				rem      <= fits ? trial[W-1:0] : shifted[W-1:0];
				quotient <= {quotient[W-2:0], fits};
				cnt      <= cnt - 8'h01;
				if (cnt == 8'h01) begin
					done <= 1'b1;
				end
			end
		end
	end
endmodule

// >>> hw/aos_scaler.v
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
`include "aos_defines.vh"

module aos_scaler #(
	parameter [1:0]  OUT_KIND   = `AOS_KIND_ACUR,
	parameter [31:0] SEC_CYCLES = `AOS_SEC_NS / `AOS_CLK_NS
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire        hready,
	input  wire [31:0] hwdata,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire [31:0] live_value,
	input  wire [31:0] held_value,
	input  wire        critical,
	input  wire        mb_frame,
	input  wire        mb_level_we,
	input  wire [15:0] mb_level,
	output reg  [15:0] dac_code,
	output reg         irq
);
	localparam [31:0] SEC_LAST = SEC_CYCLES - 32'h00000001;
	localparam [1:0]  ST_IDLE  = 2'h0;
	localparam [1:0]  ST_DIV   = 2'h1;
	localparam [1:0]  ST_ADD   = 2'h2;
	// widest span of this version, used to window bus levels
	localparam [2:0]  WIDE_MODE = (OUT_KIND == `AOS_KIND_AVOLT) ? `AOS_MODE_0_10 :
		(OUT_KIND == `AOS_KIND_PCUR) ? `AOS_MODE_4_20 : `AOS_MODE_0_20;

	// mode allowed for this version
	function mode_ok;
		input [2:0] m;
		begin
			case (OUT_KIND)
				`AOS_KIND_ACUR:  mode_ok = (m <= `AOS_MODE_4_20) ||
					(m == `AOS_MODE_BUS);
				`AOS_KIND_PCUR:  mode_ok = (m == `AOS_MODE_OFF) ||
					(m == `AOS_MODE_4_20) || (m == `AOS_MODE_BUS);
				default:         mode_ok = (m == `AOS_MODE_OFF) ||
					(m >= `AOS_MODE_0_5);
			endcase
		end
	endfunction

	// fault choice allowed for this version
	function choice_ok;
		input [2:0] c;
		begin
			case (OUT_KIND)
				`AOS_KIND_ACUR:  choice_ok = (c <= 3'h3);
				`AOS_KIND_PCUR:  choice_ok = (c <= 3'h2);
				default:         choice_ok = (c <= 3'h5);
			endcase
		end
	endfunction

	// span lower limit A
	function [15:0] span_lo;
		input [2:0] m;
		begin
			case (m)
				`AOS_MODE_4_20: span_lo = `AOS_LV_4MA;
				`AOS_MODE_1_5:  span_lo = `AOS_LV_1V;
				`AOS_MODE_2_10: span_lo = `AOS_LV_2V;
				default:        span_lo = `AOS_LV_0;
			endcase
		end
	endfunction

	// span upper limit B
	function [15:0] span_hi;
		input [2:0] m;
		begin
			case (m)
				`AOS_MODE_0_20, `AOS_MODE_4_20: span_hi = `AOS_LV_20MA;
				`AOS_MODE_0_5, `AOS_MODE_1_5:   span_hi = `AOS_LV_5V;
				`AOS_MODE_0_10, `AOS_MODE_2_10: span_hi = `AOS_LV_10V;
				default:                        span_hi = `AOS_LV_0;
			endcase
		end
	endfunction

	// substitute level for a fault choice
	function [15:0] fault_lv;
		input [2:0] c;
		begin
			if (OUT_KIND == `AOS_KIND_AVOLT) begin
				case (c)
					3'h1:    fault_lv = `AOS_LV_11V;
					3'h2:    fault_lv = `AOS_LV_5_5V;
					3'h3:    fault_lv = `AOS_LV_1_2V;
					3'h4:    fault_lv = `AOS_LV_0_6V;
					default: fault_lv = `AOS_LV_0;
				endcase
			end else begin
				case (c)
					3'h1:    fault_lv = `AOS_LV_22_1MA;
					3'h2:    fault_lv = `AOS_LV_3_4MA;
					default: fault_lv = `AOS_LV_0;
				endcase
			end
		end
	endfunction

	// clamp a signed value into the window
	function [15:0] clamp;
		input signed [51:0] v;
		input [15:0]        lo;
		input [15:0]        hi;
		begin
			if (v < $signed({36'h0, lo})) begin
				clamp = lo;
			end else if (v > $signed({36'h0, hi})) begin
				clamp = hi;
			end else begin
				clamp = v[15:0];
			end
		end
	endfunction

	// software settings, sticky status and the link level
	reg  [6:0]  ctrl;            // mode, source, fault choice
	reg  [31:0] scale_low_point;  // signed source value for span lower limit
	reg  [31:0] scale_high_point; // signed source value for span upper limit
	reg  [16:0] lower_extension_pct;
	reg  [16:0] upper_extension_pct;
	reg  [6:0]  frame_gap_limit;  // seconds, zero disables
	reg  [3:0]  stat;             // sticky events
	reg  [3:0]  mask;             // interrupt enables
	reg  [15:0] bus_level;        // last level from the link

	wire [2:0]  mode = ctrl[`AOS_CTRL_MODE];
	wire        output_source_select = ctrl[`AOS_CTRL_SRC];
	wire [2:0]  fault_output_choice  = ctrl[`AOS_CTRL_FLT];
	wire        keep_level = (fault_output_choice == `AOS_FLT_KEEP);
	wire [2:0]  eff_mode   = (mode == `AOS_MODE_BUS) ? WIDE_MODE : mode;
	wire [15:0] lim_a      = span_lo(eff_mode);
	wire [15:0] lim_b      = span_hi(eff_mode);

	// window borders; constant divide truncates toward the span
	wire [32:0] lo_cut = ({17'h0, lim_a} * {16'h0, lower_extension_pct}) /
		`AOS_PCT_FULL;
	wire [32:0] hi_add = ({17'h0, lim_b} * {16'h0, upper_extension_pct}) /
		`AOS_PCT_FULL;
	wire [15:0] win_lo = lim_a - lo_cut[15:0];
	wire [15:0] win_hi = lim_b + hi_add[15:0];

	// scaling operands
	wire [31:0]        src_w  = output_source_select ? held_value : live_value;
	wire signed [32:0] diff_w = $signed({src_w[31], src_w}) -
		$signed({scale_low_point[31], scale_low_point});
	wire signed [32:0] den_w  = $signed({scale_high_point[31], scale_high_point}) -
		$signed({scale_low_point[31], scale_low_point});
	wire [15:0]        span_w = lim_b - lim_a;
	wire signed [49:0] num_w  = diff_w * $signed({1'b0, span_w});
	wire [49:0]        num_mag = num_w[49] ? (~num_w + 50'h1) : num_w;
	wire [32:0]        den_mag = den_w[32] ? (~den_w + 33'h1) : den_w;

	// division state
	reg  [1:0]  calc_state;
	reg         div_start;
	reg         neg_q;          // quotient sign; low above high flips it
	reg  [15:0] scaled_code;    // last scaled and clamped result
	reg         clamp_ev;       // one-cycle clamp event
	wire        div_done;
	wire [49:0] div_q;

	aos_divider #(
		.W        (50)
	) u_div (
		.clk      (hclk),
		.rstn     (hresetn),
		.start    (div_start),
		.dividend (num_mag),
		.divisor  ({17'h0, den_mag}),
		.done     (div_done),
		.quotient (div_q)
	);

	wire signed [51:0] q_s   = neg_q ? -$signed({2'b00, div_q}) : $signed({2'b00, div_q});
	wire signed [51:0] sum_w = q_s + $signed({36'h0, lim_a});

	// scaling loop: sample operands, divide, add A and clamp
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			calc_state  <= ST_IDLE;
			div_start   <= 1'b0;
			neg_q       <= 1'b0;
			scaled_code <= 16'h0000;
			clamp_ev    <= 1'b0;
		end else begin
			div_start <= 1'b0;
			clamp_ev  <= 1'b0;
			case (calc_state)
				ST_IDLE: begin
					if (den_w == 33'h0) begin
						scaled_code <= lim_a;
					end else begin
						neg_q      <= num_w[49] ^ den_w[32];
						div_start  <= 1'b1;
						calc_state <= ST_DIV;
					end
				end
				ST_DIV: begin
					if (div_done) begin
						calc_state <= ST_ADD;
					end
				end
				ST_ADD: begin
					scaled_code <= clamp(sum_w, win_lo, win_hi);
					clamp_ev    <= (sum_w < $signed({36'h0, win_lo})) ||
						(sum_w > $signed({36'h0, win_hi}));
					calc_state  <= ST_IDLE;
				end
				default: calc_state <= ST_IDLE;
			endcase
		end
	end

	// frame gap watchdog on a one-second enable
	reg  [31:0] pre_cnt;
	reg  [6:0]  sec_cnt;          // whole seconds since the last frame
	reg         gap_exp;          // bus output in its fault state
	reg         fault_q;          // previous fault level for edge events
	reg         gap_q;
	wire        sec_tick = (pre_cnt == SEC_LAST);

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pre_cnt <= 32'h0;
			sec_cnt <= 7'h00;
			gap_exp <= 1'b0;
		end else begin
			if (mb_frame) begin
				// a frame restarts the gap measurement
				pre_cnt <= 32'h0;
				sec_cnt <= 7'h00;
			end else if (sec_tick) begin
				pre_cnt <= 32'h0;
				if (sec_cnt != 7'h7f) begin
					sec_cnt <= sec_cnt + 7'h01;
				end
			end else begin
				pre_cnt <= pre_cnt + 32'h1;
			end
			gap_exp <= (mode == `AOS_MODE_BUS) && (frame_gap_limit != 7'h00) &&
				(sec_cnt >= frame_gap_limit) && !mb_frame;
		end
	end

	wire fault_act = critical || gap_exp;

	// output code selection
	reg [15:0] next_code;
	always @* begin
		if (mode == `AOS_MODE_OFF) begin
			next_code = `AOS_LV_0;
		end else if (fault_act) begin
			// keep choice freezes the present code
			next_code = keep_level ? dac_code : fault_lv(fault_output_choice);
		end else if (mode == `AOS_MODE_BUS) begin
			next_code = clamp({36'h0, bus_level}, win_lo, win_hi);
		end else begin
			next_code = scaled_code;
		end
	end

	// bus slave: writes complete in the data phase, reads take one wait
	reg        wr_pend;
	reg        rd_pend;
	reg  [7:0] ph_addr;
	wire       take  = hsel && hready && htrans[1];
	wire       wr_go = wr_pend;
	reg  [3:0] ev;
	reg  [3:0] clr;
	reg  [3:0] next_stat;
	reg  [31:0] rd_mux;

	// event collection; set wins over a write-one clear
	always @* begin
		ev = 4'h0;
		ev[`AOS_EV_CLAMP] = clamp_ev;
		ev[`AOS_EV_FAULT] = fault_act && !fault_q;
		ev[`AOS_EV_GAP]   = gap_exp && !gap_q;
		ev[`AOS_EV_REJECT] = wr_go && (ph_addr == `AOS_OFF_CTRL) &&
			!(mode_ok(hwdata[2:0]) && choice_ok(hwdata[6:4]));
		clr = (wr_go && (ph_addr == `AOS_OFF_STAT)) ? hwdata[3:0] : 4'h0;
		next_stat = (stat & ~clr) | ev;
	end

	// read data for the latched address
	always @* begin
		case (ph_addr)
			`AOS_OFF_CTRL: rd_mux = {25'h0, ctrl};
			`AOS_OFF_SLO:  rd_mux = scale_low_point;
			`AOS_OFF_SHI:  rd_mux = scale_high_point;
			`AOS_OFF_LEXT: rd_mux = {15'h0, lower_extension_pct};
			`AOS_OFF_HEXT: rd_mux = {15'h0, upper_extension_pct};
			`AOS_OFF_GAP:  rd_mux = {25'h0, frame_gap_limit};
			`AOS_OFF_STAT: rd_mux = {28'h0, stat};
			`AOS_OFF_MASK: rd_mux = {28'h0, mask};
			`AOS_OFF_OUT:  rd_mux = {16'h0, dac_code};
			default:       rd_mux = 32'h0;
		endcase
	end

	wire [16:0] lext_max = (OUT_KIND == `AOS_KIND_PCUR) ? `AOS_LEXT_MAX_P : `AOS_LEXT_MAX_A;
	wire [16:0] hext_max = (OUT_KIND == `AOS_KIND_AVOLT) ? `AOS_HEXT_MAX_V : `AOS_HEXT_MAX_C;

	// bus handshake, register file and outputs
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata              <= 32'h0;
			hreadyout           <= 1'b1;
			hresp               <= 1'b0;
			wr_pend             <= 1'b0;
			rd_pend             <= 1'b0;
			ph_addr             <= 8'h00;
			ctrl                <= `AOS_CTRL_RST;
			scale_low_point     <= 32'h0;
			scale_high_point    <= 32'h0;
			lower_extension_pct <= 17'h0;
			upper_extension_pct <= 17'h0;
			frame_gap_limit     <= 7'h00;
			stat                <= 4'h0;
			mask                <= 4'h0;
			bus_level           <= 16'h0000;
			dac_code            <= 16'h0000;
			irq                 <= 1'b0;
			fault_q             <= 1'b0;
			gap_q               <= 1'b0;
		end else begin
			wr_pend <= 1'b0;
			rd_pend <= 1'b0;
			// address phase: unmapped words read zero and ignore writes
			if (take && !rd_pend) begin
				ph_addr <= {haddr[7:2], 2'b00};
				wr_pend <= hwrite;
				if (!hwrite) begin
					rd_pend   <= 1'b1;
					hreadyout <= 1'b0;
				end
			end
			if (rd_pend) begin
				hrdata    <= rd_mux;
				hreadyout <= 1'b1;
			end
			if (haddr[31:8] != 24'h0 && take) begin
				ph_addr <= 8'hff;
			end
			if (wr_go) begin
				case (ph_addr)
					`AOS_OFF_CTRL: begin
						if (mode_ok(hwdata[2:0])) begin
							ctrl[`AOS_CTRL_MODE] <= hwdata[2:0];
						end
						if (choice_ok(hwdata[6:4])) begin
							ctrl[`AOS_CTRL_FLT] <= hwdata[6:4];
						end
						ctrl[`AOS_CTRL_SRC] <= hwdata[3];
					end
					`AOS_OFF_SLO:  scale_low_point  <= hwdata;
					`AOS_OFF_SHI:  scale_high_point <= hwdata;
					`AOS_OFF_LEXT: lower_extension_pct <= (hwdata[31:17] != 15'h0 ||
						hwdata[16:0] > lext_max) ? lext_max : hwdata[16:0];
					`AOS_OFF_HEXT: upper_extension_pct <= (hwdata[31:17] != 15'h0 ||
						hwdata[16:0] > hext_max) ? hext_max : hwdata[16:0];
					`AOS_OFF_GAP:  frame_gap_limit <= (hwdata[31:7] != 25'h0 ||
						hwdata[6:0] > `AOS_GAP_MAX) ? `AOS_GAP_MAX : hwdata[6:0];
					`AOS_OFF_MASK: mask <= hwdata[3:0];
					default: ;
				endcase
			end
			// link writes are kept whatever the mode
			if (mb_level_we) begin
				bus_level <= mb_level;
			end
			stat     <= next_stat;
			irq      <= |(next_stat & mask);
			fault_q  <= fault_act;
			gap_q    <= gap_exp;
			dac_code <= next_code;
		end
	end
endmodule

// >>> sim/analog_output_scaler_test.sv
`timescale 1ns/100ps
`include "aos_defines.vh"
module analog_output_scaler_test;
	reg         hclk, hresetn, hsel, hwrite, critical, mb_frame, mb_level_we;
	reg  [31:0] haddr, hwdata, live_value, held_value, rd;
	reg  [1:0]  htrans;
	reg  [2:0]  hsize, m;
	reg  [15:0] mb_level;
	wire [31:0] hrdata, updates;
	wire        hreadyout, hresp, irq;
	wire [15:0] dac_code, level;
	integer     bad_count, samples_checked, seed, i, c, lv, hv;
	longint     lo, hi, le, he;
	// short sim second keeps the gap timer test brief
	aos_scaler #(.OUT_KIND(`AOS_KIND_ACUR), .SEC_CYCLES(32'd400)) dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .live_value(live_value),
		.held_value(held_value), .critical(critical), .mb_frame(mb_frame),
		.mb_level_we(mb_level_we), .mb_level(mb_level), .dac_code(dac_code), .irq(irq));
	aos_conv_model conv_u (.hclk(hclk), .hresetn(hresetn), .dac_code(dac_code),
		.level(level), .updates(updates));
	always #2.5 hclk = ~hclk;
	task results;
		if (bad_count == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		samples_checked += 1;
		if (seen !== exp) begin
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
			bad_count += 1;
		end
	endtask
	// bounded wait for hready high at a rising edge
	task wait_rdy;
		integer n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n += 1;
			if (n > 20) begin
				bad_count += 1;
				results;
			end
			@(posedge hclk);
		end
	endtask
	// one single word transfer: address phase, then data phase
	task bus(input logic wr, input [31:0] a, input [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= a;
		wait_rdy;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy;
		rd = hrdata;
	endtask
	task rchk(input [31:0] a, input [31:0] mk, input [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd & mk, exp);
	endtask
	task cfg(input [2:0] md, input [6:0] hi_bits);
		bus(1'b1, `AOS_OFF_CTRL, {25'h0, hi_bits[3:0], md});
		bus(1'b1, `AOS_OFF_SLO, lo[31:0]);
		bus(1'b1, `AOS_OFF_SHI, hi[31:0]);
		bus(1'b1, `AOS_OFF_LEXT, le[31:0]);
		bus(1'b1, `AOS_OFF_HEXT, he[31:0]);
	endtask
	// frame and level pulses from the link, one cycle each
	task pulse(input logic f, input logic we);
		mb_frame <= f;
		mb_level_we <= we;
		@(posedge hclk);
		mb_frame <= 1'b0;
		mb_level_we <= 1'b0;
		@(posedge hclk);
	endtask
	// scaled, then clamped to the extended window, for the current spans
	function [15:0] expect_out(input [2:0] md, input longint w, l, h, x, y);
		longint a, b, o, wl, wh;
		a = (md == `AOS_MODE_4_20) ? 4000 : 0;
		b = 20000;
		o = (h == l) ? a : (w - l) * (b - a) / (h - l) + a;
		wl = a - a * x / 100000;
		wh = b + b * y / 100000;
		if (o < wl)
			o = wl;
		if (o > wh)
			o = wh;
		return o[15:0];
	endfunction
	initial begin
		seed = 32'h7cba4b8e;
		{hclk, hresetn, hsel, hwrite, critical, mb_frame, mb_level_we} = 7'h00;
		{haddr, hwdata, live_value, held_value, htrans, mb_level} = 0;
		hsize = 3'h2;
		bad_count = 0;
		samples_checked = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk(`AOS_OFF_CTRL, 32'h7f, 32'h0);
		bus(1'b1, `AOS_OFF_LEXT, 32'h0001ffff);
		rchk(`AOS_OFF_LEXT, 32'h1ffff, `AOS_LEXT_MAX_A);
		bus(1'b1, `AOS_OFF_HEXT, 32'h000fffff);
		rchk(`AOS_OFF_HEXT, 32'h1ffff, `AOS_HEXT_MAX_C);
		bus(1'b1, 32'h00000100, 32'h5);
		rchk(32'h00000100, 32'hffffffff, 32'h0);
		// random scaling, first pass with equal points, second far out of window
		for (i = 0; i < 14; i++) begin
			m = ($random(seed) & 1) ? `AOS_MODE_4_20 : `AOS_MODE_0_20;
			lo = $random(seed) % 2000;
			hi = (i == 0) ? lo : $random(seed) % 2000;
			le = {$random(seed)} % 100000;
			he = {$random(seed)} % 20000;
			c = $random(seed) & 1;
			lv = (i == 1) ? 900000 : $random(seed) % 3000;
			hv = $random(seed) % 3000;
			live_value <= lv;
			held_value <= hv;
			cfg(m, {3'h0, c[0]});
			repeat (160) @(posedge hclk);
			chk(level, expect_out(m, c ? hv : lv, lo, hi, le, he));
		end
		// fault levels during a critical situation, then recovery
		{lo, hi, le, he} = {64'd0, 64'd1000, 64'd0, 64'd0};
		live_value <= 32'd500;
		for (c = 0; c < 4; c++) begin
			cfg(`AOS_MODE_4_20, {c[2:0], 1'b0});
			// let the new scaling settle so that keep freezes the right level
			repeat (160) @(posedge hclk);
			critical <= 1'b1;
			repeat (160) @(posedge hclk);
			chk(level, c == 0 ? 16'd12000 : c == 1 ? `AOS_LV_22_1MA : c == 2 ? `AOS_LV_3_4MA : 0);
			critical <= 1'b0;
			repeat (160) @(posedge hclk);
			chk(level, 16'd12000);
		end
		rchk(`AOS_OFF_STAT, 32'h2, 32'h2);
		cfg(`AOS_MODE_OFF, 4'h2);
		critical <= 1'b1;
		repeat (160) @(posedge hclk);
		chk(level, 16'h0000);
		critical <= 1'b0;
		// modes that a current output does not offer are refused
		for (c = 3; c < 7; c++) begin
			bus(1'b1, `AOS_OFF_CTRL, c);
			rchk(`AOS_OFF_CTRL, 32'h7, 32'h0);
			rchk(`AOS_OFF_STAT, 32'h8, 32'h8);
		end
		// link-driven level, gap timeout, then timer disabled
		bus(1'b1, `AOS_OFF_GAP, 32'h1);
		bus(1'b1, `AOS_OFF_CTRL, {25'h0, 4'h2, `AOS_MODE_BUS});
		mb_level <= 16'd12345;
		pulse(1'b1, 1'b1);
		repeat (100) @(posedge hclk);
		chk(level, 16'd12345);
		// clear the gap bit first so only the real timeout counts
		bus(1'b1, `AOS_OFF_STAT, 32'h4);
		repeat (1000) @(posedge hclk);
		chk(level, `AOS_LV_22_1MA);
		rchk(`AOS_OFF_STAT, 32'h4, 32'h4);
		bus(1'b1, `AOS_OFF_GAP, 32'h0);
		mb_level <= 16'd7000;
		pulse(1'b1, 1'b1);
		repeat (1000) @(posedge hclk);
		chk(level, 16'd7000);
		// clamp event raises the interrupt only while unmasked
		bus(1'b1, `AOS_OFF_MASK, 32'h1);
		live_value <= 32'd900000;
		cfg(`AOS_MODE_4_20, 4'h0);
		repeat (160) @(posedge hclk);
		chk(irq, 1'b1);
		bus(1'b1, `AOS_OFF_MASK, 32'h0);
		repeat (3) @(posedge hclk);
		chk(irq, 1'b0);
		live_value <= 32'd500;
		repeat (160) @(posedge hclk);
		bus(1'b1, `AOS_OFF_STAT, 32'hf);
		bus(1'b1, `AOS_OFF_MASK, 32'hf);
		repeat (3) @(posedge hclk);
		chk(irq, 1'b0);
		rchk(`AOS_OFF_STAT, 32'hf, 32'h0);
		// second reset in mid-run
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk(`AOS_OFF_CTRL, 32'h7f, 32'h0);
		chk(level, 32'h0);
		chk(updates, 32'h0);
		results;
	end
endmodule

// >>> sim/aos_conv_model.sv
`timescale 1ns/100ps
// converter on the far side: takes each new code as its loop level
module aos_conv_model (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire [15:0] dac_code,
	output reg  [15:0] level,
	output reg  [31:0] updates
);
	// loop rests at zero while the block is held in reset
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			level   <= 16'h0000;
			updates <= 32'h00000000;
		end else if (dac_code !== level) begin
			level   <= dac_code;
			updates <= updates + 32'h00000001;
		end
	end
endmodule

// >>> sim/aos_scaler_monitor.sv
`timescale 1ns/100ps
// watches the bus handshake and the converter code at the top ports
module aos_scaler_monitor #(
	parameter [1:0] OUT_KIND = 2'h0
) (
	input wire        hclk,
	input wire        hresetn,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [2:0]  hsize,
	input wire        hready,
	input wire [31:0] hwdata,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire        hresp,
	input wire [31:0] live_value,
	input wire [31:0] held_value,
	input wire        critical,
	input wire        mb_frame,
	input wire        mb_level_we,
	input wire [15:0] mb_level,
	input wire [15:0] dac_code,
	input wire        irq
);
	// highest legal code: voltage fault at 11 V, current window top below 24 mA
	localparam int DAC_MAX = (OUT_KIND == 2'h2) ? 11000 : 23999;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// transfers the slave takes
	sequence read_taken;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence write_taken;
		hsel && hready && htrans[1] && hwrite;
	endsequence
	// exactly one wait state, then ready again
	sequence one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	read_wait_a: assert property (read_taken |=> one_wait)
		else $error("read did not take one wait state");
	write_nowait_a: assert property (write_taken |=> hreadyout)
		else $error("write was stalled");
	wait_single_a: assert property (!hreadyout |=> hreadyout)
		else $error("wait state longer than one cycle");
	wait_cause_a: assert property ($fell(hreadyout) |->
		($past(hsel) && $past(hready) && $past(htrans[1]) && !$past(hwrite)))
		else $error("wait state without a read");
	hresp_okay_a: assert property (hresp == 1'b0)
		else $error("response not okay");
	// read data may only move when a read completes
	rdata_hold_a: assert property (!$stable(hrdata) |-> $rose(hreadyout))
		else $error("read data moved outside a read");
	dac_window_a: assert property (dac_code <= DAC_MAX)
		else $error("converter code above the highest level");
	reset_quiet_a: assert property ($rose(hresetn) |-> (!irq && dac_code == 16'h0000 && hreadyout))
		else $error("outputs not quiet after reset");
endmodule

bind aos_scaler aos_scaler_monitor #(.OUT_KIND(OUT_KIND)) mon_u (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .live_value(live_value), .held_value(held_value),
	.critical(critical), .mb_frame(mb_frame), .mb_level_we(mb_level_we),
	.mb_level(mb_level), .dac_code(dac_code), .irq(irq)
);
